// File: include/tft_timing_pkg.sv
// constants and carrier types for the tft format and line sync block
package tft_timing_pkg;

  // indexed register map (index written through the index port)
  localparam logic [7:0] IDX_FORMAT_DELAY  = 8'h09;
  localparam logic [7:0] IDX_SYNC_POSITION = 8'h0a;

  // tft_format_and_sync_delay field layout
  localparam int DELAY_MSB  = 6;
  localparam int DELAY_LSB  = 4;
  localparam int FORMAT_MSB = 1;
  localparam int FORMAT_LSB = 0;
  localparam logic [7:0] FORMAT_DELAY_WMASK = 8'h73;

  // no documented reset value; software must program both registers
  localparam logic [7:0] FORMAT_DELAY_RESET  = 8'h00;
  localparam logic [7:0] SYNC_POSITION_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET         = 8'h00;

  // character clock timing, in video dot clocks
  localparam int         DOTS_PER_CHAR = 8;
  localparam logic [2:0] DOT_CNT_LAST  = 3'(DOTS_PER_CHAR - 1);

  typedef enum logic [1:0] {
    PANEL_9BIT,
    PANEL_12BIT,
    PANEL_18BIT
  } panel_format_t;

  // configuration word carried across into the dot clock domain
  typedef struct packed {
    logic [7:0] position;
    logic [2:0] delay;
    logic [1:0] format;
  } link_cfg_t;

  // one access on the indexed i/o port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       dataSel;
    logic [7:0] wdata;
  } io_req_t;

endpackage

// File: src/level_sync.sv
// two flip-flop synchroniser for a single level
`timescale 1ns/10ps
module level_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic firstStage;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstStage <= 1'b0;
      syncOut    <= 1'b0;
    end else begin
      firstStage <= asyncIn;
      syncOut    <= firstStage;
    end
  end

endmodule // level_sync

// File: src/tft_panel_format_and_line_sync.sv
// tft panel data format select and delayed panel line sync generation
//
// Operation
// R1: timing registers reachable only while unlock set
// R2: line sync delayed 0-7 dot clocks
// R3: character clock is eight dot clocks
// R4: delay field bit six is msb
// R5: format 00=9bit, 10=12bit, x1=18bit
// R6: eight-bit compare sets line sync position
// R7: position counts in eight-dot character units
// R8: software programs both registers before use
// R9: sync on counter match, then dot delay
// R10: format reserved bits read zero, ignore writes
`timescale 1ns/10ps
module tft_panel_format_and_line_sync (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire tft_timing_pkg::io_req_t      ioReq,
  input  wire logic                         extendedTimingUnlockBit,
  output logic [7:0]                        ioRdData,
  input  wire logic                         videoDotClock,
  input  wire logic                         lineRestart,
  output logic                              panelLineSyncOutput,
  output tft_timing_pkg::panel_format_t     panelFormat
);

  // register side, mclk domain
  logic [7:0] indexReg;
  logic [7:0] tftFormatAndSyncDelay;
  logic [7:0] tftLineSyncPosition;
  logic       regAccessOk;
  logic       dataWrite;
  logic       cfgDirty;
  logic       reqToggle;
  logic       ackSynced;
  tft_timing_pkg::link_cfg_t xferWord;

  // extended timing registers are hidden while locked
  assign regAccessOk = extendedTimingUnlockBit; // R1
  assign dataWrite   = ioReq.wr && ioReq.dataSel && regAccessOk; // R1

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      indexReg <= tft_timing_pkg::INDEX_RESET;
    end else if (ioReq.wr && !ioReq.dataSel) begin
      indexReg <= ioReq.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tftFormatAndSyncDelay <= tft_timing_pkg::FORMAT_DELAY_RESET; // R8
    end else if (dataWrite && indexReg == tft_timing_pkg::IDX_FORMAT_DELAY) begin
      tftFormatAndSyncDelay <= ioReq.wdata & tft_timing_pkg::FORMAT_DELAY_WMASK; // R10
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tftLineSyncPosition <= tft_timing_pkg::SYNC_POSITION_RESET; // R8
    end else if (dataWrite && indexReg == tft_timing_pkg::IDX_SYNC_POSITION) begin
      tftLineSyncPosition <= ioReq.wdata; // R6
    end
  end

  // read data answers one cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ioRdData <= 8'h00;
    end else if (ioReq.rd) begin
      if (!ioReq.dataSel) begin
        ioRdData <= indexReg;
      end else if (!regAccessOk) begin
        ioRdData <= 8'h00; // R1
      end else if (indexReg == tft_timing_pkg::IDX_FORMAT_DELAY) begin
        ioRdData <= tftFormatAndSyncDelay & tft_timing_pkg::FORMAT_DELAY_WMASK; // R10
      end else if (indexReg == tft_timing_pkg::IDX_SYNC_POSITION) begin
        ioRdData <= tftLineSyncPosition;
      end else begin
        ioRdData <= 8'h00;
      end
    end
  end

  // crossing: toggle handshake carrying a held configuration word
  // a write during a transfer only marks dirty; the word stays frozen
  // until the dot side acknowledges, then the latest values go over
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfgDirty <= 1'b1;
    end else if (dataWrite) begin
      cfgDirty <= 1'b1;
    end else if (reqToggle == ackSynced) begin
      cfgDirty <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reqToggle <= 1'b0;
      xferWord  <= '0;
    end else if (cfgDirty && !dataWrite && reqToggle == ackSynced) begin
      reqToggle         <= ~reqToggle;
      xferWord.position <= tftLineSyncPosition;
      xferWord.delay    <= tftFormatAndSyncDelay[tft_timing_pkg::DELAY_MSB:tft_timing_pkg::DELAY_LSB]; // R4
      xferWord.format   <= tftFormatAndSyncDelay[tft_timing_pkg::FORMAT_MSB:tft_timing_pkg::FORMAT_LSB];
    end
  end

  // link side, video dot clock domain
  logic                      reqSynced;
  logic                      ackToggle;
  tft_timing_pkg::link_cfg_t linkCfg;
  logic [2:0]                dotCount;
  logic [7:0]                charCount;
  logic                      charMatch;
  logic [7:0]                syncPipe;
  logic [2:0]                delaySel;

  level_sync reqSync (
    .clk     (videoDotClock),
    .rst_n   (rst_n),
    .asyncIn (reqToggle),
    .syncOut (reqSynced)
  );

  level_sync ackSync (
    .clk     (mclk),
    .rst_n   (rst_n),
    .asyncIn (ackToggle),
    .syncOut (ackSynced)
  );

  // xferWord has been stable for at least two dot clocks by now
  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) begin
      ackToggle <= 1'b0;
      linkCfg   <= '0;
    end else if (reqSynced != ackToggle) begin
      ackToggle <= reqSynced;
      linkCfg   <= xferWord;
    end
  end

  // eight dot clocks make one character clock
  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) begin
      dotCount <= 3'h0;
    end else if (lineRestart || dotCount == tft_timing_pkg::DOT_CNT_LAST) begin
      dotCount <= 3'h0; // R3
    end else begin
      dotCount <= dotCount + 3'h1; // R3
    end
  end

  // horizontal character counter, one step per character clock
  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) begin
      charCount <= 8'h00;
    end else if (lineRestart) begin
      charCount <= 8'h00;
    end else if (dotCount == tft_timing_pkg::DOT_CNT_LAST) begin
      charCount <= charCount + 8'h01; // R3 R7
    end
  end

  // match level lasts one whole character clock
  assign charMatch = (charCount == linkCfg.position) && !lineRestart; // R6 R7 R9

  // one stage per dot clock; the tap picks the sub-character delay
  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) begin
      syncPipe <= 8'h00;
    end else begin
      syncPipe <= {syncPipe[6:0], charMatch}; // R9
    end
  end

  assign delaySel = linkCfg.delay; // R4

  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) begin
      panelLineSyncOutput <= 1'b0;
    end else begin
      panelLineSyncOutput <= syncPipe[delaySel]; // R2 R9
    end
  end

  function automatic tft_timing_pkg::panel_format_t decodeFormat(input logic [1:0] code);
    if (code[0]) begin
      decodeFormat = tft_timing_pkg::PANEL_18BIT;
    end else if (code[1]) begin
      decodeFormat = tft_timing_pkg::PANEL_12BIT;
    end else begin
      decodeFormat = tft_timing_pkg::PANEL_9BIT;
    end
  endfunction

  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) begin
      panelFormat <= tft_timing_pkg::PANEL_9BIT;
    end else begin
      panelFormat <= decodeFormat(linkCfg.format); // R5
    end
  end

endmodule // tft_panel_format_and_line_sync

// File: tb/tft_line_sync_props.sv
// assertions on the tft format and line sync ports
`timescale 1ns/10ps
module tft_line_sync_props (
  input wire logic                          mclk,
  input wire logic                          rst_n,
  input wire tft_timing_pkg::io_req_t       ioReq,
  input wire logic                          extendedTimingUnlockBit,
  input wire logic [7:0]                    ioRdData,
  input wire logic                          videoDotClock,
  input wire logic                          lineRestart,
  input wire logic                          panelLineSyncOutput,
  input wire tft_timing_pkg::panel_format_t panelFormat
);
  logic [7:0]  idx, fmtReg, posReg;
  logic [15:0] dc;
  logic        seen;
  wire up = extendedTimingUnlockBit;
  wire ls = panelLineSyncOutput;
  wire rdD = ioReq.rd && ioReq.dataSel;
  wire wrD = ioReq.wr && ioReq.dataSel && up;
  wire [15:0] ePos = {5'h00, posReg, 3'h2} + 16'(fmtReg[6:4]);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {idx, fmtReg, posReg} <= '0;
    end else begin
      if (ioReq.wr && !ioReq.dataSel) idx <= ioReq.wdata;
      if (wrD && idx == 8'h09) fmtReg <= ioReq.wdata & 8'h73;
      if (wrD && idx == 8'h0a) posReg <= ioReq.wdata;
    end
  end
  // line timing only judged once a restart has aligned our dot count
  always_ff @(posedge videoDotClock or negedge rst_n) begin
    if (!rst_n) {dc, seen} <= '0;
    else {dc, seen} <= lineRestart ? 17'h00001 : {dc + 16'h0001, seen};
  end
  property p_lock; @(posedge mclk) disable iff (!rst_n) rdD && !up |=> ioRdData == 8'h00; endproperty
  a_lock: assert property (p_lock) else $error("locked read not zero");
  property p_pos; @(posedge mclk) disable iff (!rst_n) rdD && up && idx == 8'h0a |=> ioRdData == posReg; endproperty
  a_pos: assert property (p_pos) else $error("position readback");
  property p_rsv; @(posedge mclk) disable iff (!rst_n) rdD && up && idx == 8'h09 |=> ioRdData == fmtReg; endproperty
  a_rsv: assert property (p_rsv) else $error("format readback");
  property p_hold; @(posedge mclk) disable iff (!rst_n) !ioReq.rd |=> $stable(ioRdData); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wid; @(posedge videoDotClock) disable iff (!rst_n) seen && $rose(ls) |-> ls[*8] ##1 !ls; endproperty
  a_wid: assert property (p_wid) else $error("sync width");
  property p_at; @(posedge videoDotClock) disable iff (!rst_n) seen && $rose(ls) |-> dc == ePos; endproperty
  a_at: assert property (p_at) else $error("sync position");
  property p_dly; @(posedge videoDotClock) disable iff (!rst_n) seen && $rose(ls) |-> dc[2:0] == fmtReg[6:4] + 3'h2;
  endproperty
  a_dly: assert property (p_dly) else $error("sync delay");
  property p_fmt; @(posedge videoDotClock) disable iff (!rst_n)
    seen && $rose(ls) |-> panelFormat == (fmtReg[0] ? 2'h2 : {1'b0, fmtReg[1]}); endproperty
  a_fmt: assert property (p_fmt) else $error("panel format");
  c_line: cover property (@(posedge videoDotClock) seen && $rose(ls));
  c_lock: cover property (@(posedge mclk) rdD && !up);
  c_rsv: cover property (@(posedge mclk) rdD && up && idx == 8'h09);
endmodule // tft_line_sync_props

// File: tb/tft_panel_model.sv
// panel side: measures each line sync pulse in dot clocks
`timescale 1ns/10ps
module tft_panel_model (
  input wire logic dck,
  input wire logic rst_n,
  input wire logic lineSync,
  output int       width
);
  int run;
  always_ff @(posedge dck or negedge rst_n) begin
    if (!rst_n) begin
      run <= 0;
      width <= 0;
    end else begin
      run <= lineSync ? run + 1 : 0;
      if (!lineSync && run != 0) width <= run;
    end
  end
endmodule // tft_panel_model

// File: tb/tb_top.sv
// self-checking bench for the tft format and line sync block
`timescale 1ns/10ps
module tb_top;
  logic                          mclk = 1'b0, dck = 1'b0, rst_n = 1'b0, up = 1'b0, rs = 1'b0, sync;
  tft_timing_pkg::io_req_t       req = '0;
  tft_timing_pkg::panel_format_t fmt;
  logic [7:0]                    rdData;
  int                            width, errors = 0, cmp_count = 0, cyc = 0;
  tft_panel_format_and_line_sync tft_panel_format_and_line_sync_inst (.mclk(mclk), .rst_n(rst_n), .ioReq(req),
    .extendedTimingUnlockBit(up), .ioRdData(rdData), .videoDotClock(dck), .lineRestart(rs),
    .panelLineSyncOutput(sync), .panelFormat(fmt));
  tft_panel_model tft_panel_model_inst (.dck(dck), .rst_n(rst_n), .lineSync(sync), .width(width));
  initial forever #2 mclk = ~mclk;
  initial begin
    #7;
    forever #24 dck = ~dck;
  end
  task automatic complete_run();
    $display("%0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic io(input logic w, r, s, input logic [7:0] d);
    @(negedge mclk);
    req <= '{w, r, s, d};
    @(negedge mclk);
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] i, d);
    io(1'b1, 1'b0, 1'b0, i);
    io(1'b1, 1'b0, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] i, exp);
    io(1'b1, 1'b0, 1'b0, i);
    io(1'b0, 1'b1, 1'b1, 8'h00);
    @(negedge mclk);
    check({8'h00, rdData}, {8'h00, exp});
  endtask
  task automatic t_regs();
    up <= 1'b1;
    wr(8'h09, 8'h21);
    up <= 1'b0;
    wr(8'h09, 8'h52);
    rd(8'h09, 8'h00);
    up <= 1'b1;
    rd(8'h09, 8'h21);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h73);
    wr(8'h0a, 8'ha5);
    rd(8'h0a, 8'ha5);
    rd(8'h05, 8'h00);
    $display("register test done");
  endtask
  // positions fall from line to line so the free-running count never meets them early
  task automatic t_line(input logic [1:0] f, input logic [7:0] p, input logic [2:0] d);
    int k = 0;
    wr(8'h09, {1'b0, d, 2'b00, f});
    wr(8'h0a, p);
    repeat (30) @(negedge dck);
    rs <= 1'b1;
    @(negedge dck);
    rs <= 1'b0;
    while (sync !== 1'b1 && k < 3000) begin
      @(posedge dck);
      #1 k++;
    end
    check(16'(k), {5'h00, p, 3'h2} + 16'(d));
    check(16'(fmt), f[0] ? 16'h0002 : {15'h0000, f[1]});
    repeat (12) @(posedge dck);
    check(16'(width), 16'h0008);
    $display("line test done");
  endtask
  initial begin
    repeat (10) @(negedge dck);
    @(negedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_line(2'b00, 8'h09, 3'h0);
    t_line(2'b10, 8'h05, 3'h4);
    t_line(2'b01, 8'h01, 3'h7);
    t_line(2'b11, 8'h00, 3'h1);
    complete_run();
  end
endmodule // tb_top
bind tft_panel_format_and_line_sync tft_line_sync_props tft_line_sync_props_inst (.mclk(mclk), .rst_n(rst_n),
  .ioReq(ioReq), .extendedTimingUnlockBit(extendedTimingUnlockBit), .ioRdData(ioRdData),
  .videoDotClock(videoDotClock), .lineRestart(lineRestart), .panelLineSyncOutput(panelLineSyncOutput),
  .panelFormat(panelFormat));
